// File: rtl/pcs_pkg.sv
// ============================================================================
// Shared constants and types of the clock synthesizer configuration block.
package pcs_pkg;

   // ==========================================================================
   // Register offsets.
   localparam logic [7:0] PCS_ADDR_PLL  = 8'h04;   // PLL and ADC clock configuration.
   localparam logic [7:0] PCS_ADDR_AUX  = 8'h06;   // Auxiliary clock output configuration.
   localparam logic [7:0] PCS_ADDR_RXF  = 8'h07;   // Receive filter and ADC control.
   localparam logic [7:0] PCS_ADDR_BIAS = 8'h13;   // ADC power bias control.

   // ==========================================================================
   // Reset values and writable bit masks; unwritable bits read as zero, except PLL bit 7.
   localparam logic [7:0] PCS_RST_PLL   = 8'h00;
   localparam logic [7:0] PCS_RST_AUX   = 8'h00;
   localparam logic [7:0] PCS_RST_RXF   = 8'h00;
   localparam logic [7:0] PCS_RST_BIAS  = 8'h00;
   localparam logic [7:0] PCS_MASK_PLL  = 8'h1F;
   localparam logic [7:0] PCS_MASK_AUX  = 8'hFF;
   localparam logic [7:0] PCS_MASK_RXF  = 8'h11;
   localparam logic [7:0] PCS_MASK_BIAS = 8'h07;
   localparam logic [7:0] PCS_RDATA_NONE = 8'h00;

   // ==========================================================================
   // Field positions.
   localparam int PCS_PLL_M_LSB       = 0;   // Multiplier exponent, two bits.
   localparam int PCS_PLL_N_LSB       = 2;   // ADC divider exponent, two bits.
   localparam int PCS_PLL_ADC_SRC_BIT = 4;   // ADC clock taken from the VCO.
   localparam int PCS_PLL_APPLIED_BIT = 7;   // Read only: source now in use.
   localparam int PCS_AUX_VCO_DIS_BIT = 0;
   localparam int PCS_AUX_VCO_INV_BIT = 1;
   localparam int PCS_AUX_VCO_DIV_LSB = 2;
   localparam int PCS_AUX_REF_DIS_BIT = 4;
   localparam int PCS_AUX_REF_INV_BIT = 5;
   localparam int PCS_AUX_REF_DIV_LSB = 6;
   localparam int PCS_RXF_LOW_PWR_BIT = 4;
   localparam int PCS_BIAS_LSB        = 0;

   // ==========================================================================
   // Exponent limits and latency figures in ADC clock edges.
   localparam logic [1:0] PCS_EXP_ZERO    = 2'h0;
   localparam logic [1:0] PCS_EXP_ONE     = 2'h1;
   localparam logic [1:0] PCS_EXP_MAX_N   = 2'h2;
   localparam logic [1:0] PCS_EXP_MAX_L   = 2'h2;
   localparam logic [4:0] PCS_LAT_ZERO    = 5'h00;
   localparam logic [4:0] PCS_LAT_ONE     = 5'h01;
   localparam logic [4:0] PCS_LAT_HALF_DX = 5'h14;   // Ten whole ADC cycles.
   localparam logic [4:0] PCS_LAT_FULL_DX = 5'h15;   // Ten and a half ADC cycles.
   localparam logic [2:0] PCS_CNT_ZERO    = 3'h0;
   localparam logic [2:0] PCS_CNT_ONE     = 3'h1;

   // Gain step latency tracker states.
   typedef enum logic {
      PCS_LAT_IDLE  = 1'b0,
      PCS_LAT_COUNT = 1'b1
   } pcs_lat_state_e;

endpackage : pcs_pkg

// File: rtl/pcs_clk_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Carrier between the configuration logic and one clock output generator.
interface pcs_clk_if;
   logic       src;     // Source clock level.
   logic [1:0] div;     // Divide exponent.
   logic       inv;     // Invert the output.
   logic       dis;     // Hold the output low.
   logic       clk_out; // Generated clock level.

   modport gen (input src, input div, input inv, input dis, output clk_out);
   modport ctl (output src, output div, output inv, output dis, input clk_out);
endinterface : pcs_clk_if
`default_nettype wire

// File: rtl/pcs_clk_gen.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Divides, inverts or blanks one clock level without runt pulses.
module pcs_clk_gen (
   input wire logic i_sys_clk, // System clock.
   input wire logic i_rst,     // Synchronous reset, active high.
   input wire logic i_ce,      // Clock enable; low freezes all state.
   pcs_clk_if.gen   bus        // Source, settings and generated clock.
);

   typedef struct packed {
      logic       src_prev;
      logic [2:0] cnt;
      logic [1:0] div;
      logic       inv;
      logic       dis;
      logic       out;
   } pcs_gen_s;

   pcs_gen_s q;
   pcs_gen_s d;
   logic     rise;
   logic     cand;
   logic     cur;

   // Output level for a given setting: bypass, a counter bit, inversion, blanking.
   function automatic logic pcs_pick(input logic       src,
                                     input logic [2:0] cnt,
                                     input logic [1:0] div,
                                     input logic       inv,
                                     input logic       dis);
      logic raw;
      raw = (div == pcs_pkg::PCS_EXP_ZERO) ? src : cnt[div - pcs_pkg::PCS_EXP_ONE];
      return dis ? 1'b0 : (raw ^ inv);
   endfunction : pcs_pick

   // ==========================================================================
   // Next state; new settings are taken only where they leave the level unchanged.
   always_comb begin
      d          = q;
      rise       = bus.src & ~q.src_prev;
      d.src_prev = bus.src;
      if (rise) begin
         d.cnt = q.cnt + pcs_pkg::PCS_CNT_ONE;
      end
      cand = pcs_pick(bus.src, d.cnt, bus.div, bus.inv, bus.dis);
      cur  = pcs_pick(bus.src, d.cnt, q.div, q.inv, q.dis);
      if (({bus.div, bus.inv, bus.dis} != {q.div, q.inv, q.dis}) && (cand == q.out)) begin // R16
         d.div = bus.div;
         d.inv = bus.inv;
         d.dis = bus.dis;
         d.out = cand;
      end else begin
         d.out = cur;
      end
      if (i_rst) begin
         // The clock keeps running undivided through reset.
         d.cnt = pcs_pkg::PCS_CNT_ZERO; // R11
         d.div = pcs_pkg::PCS_EXP_ZERO;
         d.inv = 1'b0;
         d.dis = 1'b0;
         d.out = bus.src;
      end
   end

   // State register.
   always_ff @(posedge i_sys_clk) begin
      if (i_ce) begin
         q <= d;
      end
   end

   assign bus.clk_out = q.out;

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   chk_disabled_low_level: assert property (q.dis |-> !q.out) // R16
      else $error("Disabled clock output is not low.");

   chk_switch_no_edge: assert property ( // R16
      ($past(i_ce) && ($past({q.div, q.inv, q.dis}) != {q.div, q.inv, q.dis}))
      |-> (q.out == $past(q.out)))
      else $error("Settings change produced an edge on the output.");

   chk_bypass_follows_src: assert property ( // R10
      ($past(i_ce) && !$past(i_rst) && $stable({q.div, q.inv, q.dis}) &&
       (q.div == pcs_pkg::PCS_EXP_ZERO) && !q.dis && !q.inv)
      |-> (q.out == $past(bus.src)))
      else $error("Undivided output is not a delayed copy of the source.");

   chk_div_edge_on_rise: assert property ( // R9
      ($past(i_ce) && !$past(i_rst) && $stable({q.div, q.inv, q.dis}) &&
       (q.div == pcs_pkg::PCS_EXP_ONE) && !q.dis && (q.out != $past(q.out)))
      |-> $past(bus.src && !q.src_prev))
      else $error("Divided output moved without a source rising edge.");

endmodule : pcs_clk_gen
`default_nettype wire

// File: rtl/pcs_pll_clock_synth_config.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: ADC rate equals word rate; DAC update runs at VCO rate, one, two or four times.
// R2: VCO equals reference times two to the multiplier exponent in bits 1:0.
// R3: Software picks multiplier exponent as log2 of interpolation times word rate over reference.
// R4: Bit 4 selects ADC clock source: clear is reference, set is divided VCO.
// R5: VCO-sourced ADC clock is VCO over two to exponent in bits 3:2, 0 to 2.
// R6: Full-duplex receive clock runs at twice the word rate for nibble transfer; the code keeps it at the ADC rate while the ADC exponent is zero.
// R7: Aux output register bits 7:6 divide, bit 5 invert, bit 4 disable reference output.
// R8: Aux output register bits 3:2 divide, bit 1 invert, bit 0 disable VCO output.
// R9: VCO auxiliary output is VCO over two to R, phase-locked to PLL dividers.
// R10: Reference auxiliary output is reference over two to L; zero passes delayed copy; the code treats an L of 3 as 2.
// R11: Both auxiliary outputs keep running through hardware or software reset.
// R12: Software keeps VCO within 80 to 200 MHz and reference within 20 to 80.
// R13: Gain step shows after 10.0 ADC cycles half duplex, 10.5 full duplex.
// R14: Filter control bit 4 puts the ADC into its reduced-current mode.
// R15: Power bias bits 2:0 select alternative ADC bias settings.
// R16: Disabled outputs hold low; setting changes never produce runt pulses.
// ============================================================================
// Register file and clock selection of the front end's clock synthesizer.
module pcs_pll_clock_synth_config (
   input  wire logic       i_sys_clk,            // System clock, 25 MHz.
   input  wire logic       i_rst,                // Synchronous reset, active high.
   input  wire logic       i_ce,                 // Clock enable; low freezes all state.
   input  wire logic       i_reference_clock_in, // Reference clock pin level.
   input  wire logic       i_vco_level,          // VCO output level from the analog PLL.
   input  wire logic       i_full_duplex,        // Interface mode pin, high for full duplex.
   input  wire logic       i_gain_step,          // Pulse: gain step applied at the amplifier.
   input  wire logic [7:0] i_reg_addr,           // Register address.
   input  wire logic [7:0] i_reg_wdata,          // Register write data.
   input  wire logic       i_reg_wr,             // Register write strobe.
   input  wire logic       i_reg_rd,             // Register read strobe.
   output logic      [7:0] o_reg_rdata,          // Register read data, one cycle later.
   output logic      [1:0] o_pll_mult_exp,       // Multiplier exponent to the PLL.
   output logic            o_adc_clk,            // ADC sampling clock level.
   output logic            o_adc_clk_from_vco,   // ADC clock source now in use.
   output logic            o_dac_update_clk,     // DAC update clock level.
   output logic            o_receive_clock_out,  // Receive output clock level.
   output logic            o_vco_aux_clock_out,  // VCO-derived auxiliary clock.
   output logic            o_ref_aux_clock_out,  // Reference-derived auxiliary clock.
   output logic            o_adc_low_power,      // ADC reduced-current mode.
   output logic      [2:0] o_adc_bias,           // ADC bias setting.
   output logic            o_gain_step_seen      // Pulse: the step reaches the data.
);

   typedef struct packed {
      logic [7:0]              pll_cfg;
      logic [7:0]              aux_cfg;
      logic [7:0]              rxf_cfg;
      logic [7:0]              bias_cfg;
      logic [7:0]              rdata;
      logic                    adc_src_vco;
      logic                    ref_s1;
      logic                    ref_s2;
      logic                    vco_s1;
      logic                    vco_s2;
      logic                    fd_s1;
      logic                    fd_s2;
      pcs_pkg::pcs_lat_state_e lat_state;
      logic                    lat_full;
      logic [4:0]              lat_cnt;
      logic                    adc_prev;
      logic                    seen;
   } pcs_top_s;

   pcs_top_s   q;
   pcs_top_s   d;
   logic [1:0] n_exp;
   logic [1:0] adc_exp;
   logic       adc_edge;
   logic [4:0] lat_target;

   pcs_clk_if adc_if ();
   pcs_clk_if rx_if ();
   pcs_clk_if vaux_if ();
   pcs_clk_if raux_if ();

   // Limits an exponent to its largest legal value.
   function automatic logic [1:0] pcs_clamp(input logic [1:0] e, input logic [1:0] lim);
      return (e > lim) ? lim : e;
   endfunction : pcs_clamp

   // Lowers an exponent by one when asked, never below zero.
   function automatic logic [1:0] pcs_less_one(input logic [1:0] e, input logic dec);
      return (dec && (e != pcs_pkg::PCS_EXP_ZERO)) ? (e - pcs_pkg::PCS_EXP_ONE) : e;
   endfunction : pcs_less_one

   // ==========================================================================
   // Effective exponents of the ADC clock.
   assign n_exp    = pcs_clamp(q.pll_cfg[pcs_pkg::PCS_PLL_N_LSB +: 2], pcs_pkg::PCS_EXP_MAX_N); // R5
   assign adc_exp  = q.adc_src_vco ? n_exp : q.pll_cfg[pcs_pkg::PCS_PLL_M_LSB +: 2];
   assign adc_edge = (o_adc_clk != q.adc_prev);
   assign lat_target = q.lat_full ? pcs_pkg::PCS_LAT_FULL_DX : pcs_pkg::PCS_LAT_HALF_DX;

   // ==========================================================================
   // Next state: synchronisers, register writes and reads, source switch, latency.
   always_comb begin
      d        = q;
      d.ref_s1 = i_reference_clock_in;
      d.ref_s2 = q.ref_s1;
      d.vco_s1 = i_vco_level;
      d.vco_s2 = q.vco_s1;
      d.fd_s1  = i_full_duplex;
      d.fd_s2  = q.fd_s1;
      d.adc_prev = o_adc_clk;
      d.seen   = 1'b0;

      // Register writes keep only the defined bits.
      if (i_reg_wr) begin
         if (i_reg_addr == pcs_pkg::PCS_ADDR_PLL) begin
            d.pll_cfg = i_reg_wdata & pcs_pkg::PCS_MASK_PLL; // R2
         end else if (i_reg_addr == pcs_pkg::PCS_ADDR_AUX) begin
            d.aux_cfg = i_reg_wdata & pcs_pkg::PCS_MASK_AUX; // R7 R8
         end else if (i_reg_addr == pcs_pkg::PCS_ADDR_RXF) begin
            d.rxf_cfg = i_reg_wdata & pcs_pkg::PCS_MASK_RXF; // R14
         end else if (i_reg_addr == pcs_pkg::PCS_ADDR_BIAS) begin
            d.bias_cfg = i_reg_wdata & pcs_pkg::PCS_MASK_BIAS; // R15
         end
      end

      // Register reads; unmapped addresses answer zero.
      if (i_reg_rd) begin
         if (i_reg_addr == pcs_pkg::PCS_ADDR_PLL) begin
            d.rdata = q.pll_cfg;
            d.rdata[pcs_pkg::PCS_PLL_APPLIED_BIT] = q.adc_src_vco;
         end else if (i_reg_addr == pcs_pkg::PCS_ADDR_AUX) begin
            d.rdata = q.aux_cfg;
         end else if (i_reg_addr == pcs_pkg::PCS_ADDR_RXF) begin
            d.rdata = q.rxf_cfg;
         end else if (i_reg_addr == pcs_pkg::PCS_ADDR_BIAS) begin
            d.rdata = q.bias_cfg;
         end else begin
            d.rdata = pcs_pkg::PCS_RDATA_NONE;
         end
      end

      // The ADC source moves only while the old and the new level are both low.
      if ((q.pll_cfg[pcs_pkg::PCS_PLL_ADC_SRC_BIT] != q.adc_src_vco) && !o_adc_clk &&
          !(q.pll_cfg[pcs_pkg::PCS_PLL_ADC_SRC_BIT] ? q.vco_s2 : q.ref_s2)) begin
         d.adc_src_vco = q.pll_cfg[pcs_pkg::PCS_PLL_ADC_SRC_BIT]; // R4
      end

      // Count ADC clock edges from a gain step until it shows in the data.
      case (q.lat_state)
         pcs_pkg::PCS_LAT_IDLE: begin
            if (i_gain_step) begin
               d.lat_state = pcs_pkg::PCS_LAT_COUNT;
               d.lat_full  = q.fd_s2;
               d.lat_cnt   = pcs_pkg::PCS_LAT_ZERO;
            end
         end
         pcs_pkg::PCS_LAT_COUNT: begin
            if (adc_edge) begin
               d.lat_cnt = q.lat_cnt + pcs_pkg::PCS_LAT_ONE;
               if (d.lat_cnt == lat_target) begin // R13
                  d.seen      = 1'b1;
                  d.lat_state = pcs_pkg::PCS_LAT_IDLE;
               end
            end
         end
         default: begin
            d.lat_state = pcs_pkg::PCS_LAT_IDLE;
         end
      endcase

      if (i_rst) begin
         d.pll_cfg     = pcs_pkg::PCS_RST_PLL;
         d.aux_cfg     = pcs_pkg::PCS_RST_AUX;
         d.rxf_cfg     = pcs_pkg::PCS_RST_RXF;
         d.bias_cfg    = pcs_pkg::PCS_RST_BIAS;
         d.rdata       = pcs_pkg::PCS_RDATA_NONE;
         d.adc_src_vco = 1'b0;
         d.lat_state   = pcs_pkg::PCS_LAT_IDLE;
         d.lat_full    = 1'b0;
         d.lat_cnt     = pcs_pkg::PCS_LAT_ZERO;
         d.seen        = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge i_sys_clk) begin
      if (i_ce) begin
         q <= d;
      end
   end

   // ==========================================================================
   // Clock generator settings: ADC, receive clock and the two auxiliary outputs.
   assign adc_if.src = q.adc_src_vco ? q.vco_s2 : q.ref_s2; // R4
   assign adc_if.div = q.adc_src_vco ? n_exp : pcs_pkg::PCS_EXP_ZERO; // R5 R1
   assign adc_if.inv = 1'b0;
   assign adc_if.dis = 1'b0;

   // The receive clock runs off the VCO at twice the ADC rate in full duplex while the ADC exponent is nonzero.
   assign rx_if.src = q.vco_s2;
   assign rx_if.div = pcs_less_one(adc_exp, q.fd_s2); // R6
   assign rx_if.inv = 1'b0;
   assign rx_if.dis = 1'b0;

   assign vaux_if.src = q.vco_s2;
   assign vaux_if.div = q.aux_cfg[pcs_pkg::PCS_AUX_VCO_DIV_LSB +: 2]; // R8 R9
   assign vaux_if.inv = q.aux_cfg[pcs_pkg::PCS_AUX_VCO_INV_BIT];
   assign vaux_if.dis = q.aux_cfg[pcs_pkg::PCS_AUX_VCO_DIS_BIT];

   assign raux_if.src = q.ref_s2;
   assign raux_if.div = pcs_clamp(q.aux_cfg[pcs_pkg::PCS_AUX_REF_DIV_LSB +: 2],
                                  pcs_pkg::PCS_EXP_MAX_L); // R7 R10
   assign raux_if.inv = q.aux_cfg[pcs_pkg::PCS_AUX_REF_INV_BIT];
   assign raux_if.dis = q.aux_cfg[pcs_pkg::PCS_AUX_REF_DIS_BIT];

   // Generator instances.
   pcs_clk_gen u_adc_gen (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .bus       (adc_if.gen)
   );
   pcs_clk_gen u_rx_gen (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .bus       (rx_if.gen)
   );
   pcs_clk_gen u_vaux_gen (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .bus       (vaux_if.gen)
   );
   pcs_clk_gen u_raux_gen (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .bus       (raux_if.gen)
   );

   // ==========================================================================
   // Outputs.
   assign o_reg_rdata         = q.rdata;
   assign o_pll_mult_exp      = q.pll_cfg[pcs_pkg::PCS_PLL_M_LSB +: 2]; // R2
   assign o_adc_clk           = adc_if.clk_out;
   assign o_adc_clk_from_vco  = q.adc_src_vco;
   assign o_dac_update_clk    = q.vco_s2; // R1
   assign o_receive_clock_out = rx_if.clk_out;
   assign o_vco_aux_clock_out = vaux_if.clk_out;
   assign o_ref_aux_clock_out = raux_if.clk_out;
   assign o_adc_low_power     = q.rxf_cfg[pcs_pkg::PCS_RXF_LOW_PWR_BIT]; // R14
   assign o_adc_bias          = q.bias_cfg[pcs_pkg::PCS_BIAS_LSB +: 3]; // R15
   assign o_gain_step_seen    = q.seen;

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   chk_pll_write_mult: assert property ( // R2
      (i_ce && i_reg_wr && (i_reg_addr == pcs_pkg::PCS_ADDR_PLL))
      |=> (o_pll_mult_exp == $past(i_reg_wdata[1:0])))
      else $error("Multiplier exponent did not follow the write.");

   chk_src_switch_low: assert property ( // R4
      ($past(i_ce) && (q.adc_src_vco != $past(q.adc_src_vco))) |-> !$past(o_adc_clk))
      else $error("ADC clock source switched while the clock was high.");

   chk_latency_edges: assert property ( // R13
      o_gain_step_seen |-> (q.lat_cnt ==
                            (q.lat_full ? pcs_pkg::PCS_LAT_FULL_DX : pcs_pkg::PCS_LAT_HALF_DX)))
      else $error("Gain step latency count is wrong.");

   chk_low_power_bit: assert property ( // R14
      (i_ce && i_reg_wr && (i_reg_addr == pcs_pkg::PCS_ADDR_RXF))
      |=> (o_adc_low_power == $past(i_reg_wdata[pcs_pkg::PCS_RXF_LOW_PWR_BIT])))
      else $error("ADC low power mode did not follow the write.");

   chk_bias_write: assert property ( // R15
      (i_ce && i_reg_wr && (i_reg_addr == pcs_pkg::PCS_ADDR_BIAS))
      |=> (o_adc_bias == $past(i_reg_wdata[2:0])))
      else $error("ADC bias did not follow the write.");

   chk_vco_aux_off: assert property ( // R8
      (i_ce && i_reg_wr && (i_reg_addr == pcs_pkg::PCS_ADDR_AUX) && i_reg_wdata[0])
      ##1 (i_ce && !i_reg_wr)[*8] |-> ##[0:200] !o_vco_aux_clock_out)
      else $error("VCO auxiliary output did not go low after disable.");

   chk_ref_aux_off: assert property ( // R7
      (i_ce && i_reg_wr && (i_reg_addr == pcs_pkg::PCS_ADDR_AUX) &&
       i_reg_wdata[pcs_pkg::PCS_AUX_REF_DIS_BIT])
      ##1 (i_ce && !i_reg_wr)[*8] |-> ##[0:200] !o_ref_aux_clock_out)
      else $error("Reference auxiliary output did not go low after disable.");

   chk_aux_write_taken: assert property ( // R7 R8
      (i_ce && i_reg_wr && (i_reg_addr == pcs_pkg::PCS_ADDR_AUX))
      |=> (q.aux_cfg == $past(i_reg_wdata)))
      else $error("Auxiliary settings did not follow the write.");

   chk_pll_read_back: assert property ( // R4
      (i_ce && i_reg_rd && (i_reg_addr == pcs_pkg::PCS_ADDR_PLL))
      |=> (o_reg_rdata[pcs_pkg::PCS_PLL_APPLIED_BIT] == $past(o_adc_clk_from_vco)))
      else $error("PLL readback does not show the source in use.");

   chk_seen_single_pulse: assert property ( // R13
      (i_ce && o_gain_step_seen) |=> !o_gain_step_seen)
      else $error("Gain step pulse lasted more than one cycle.");

   chk_rx_twice_adc: assert property ( // R6
      (q.fd_s2 && (adc_exp != pcs_pkg::PCS_EXP_ZERO))
      |-> (rx_if.div == (adc_exp - pcs_pkg::PCS_EXP_ONE)))
      else $error("Receive clock exponent is not one below the ADC exponent.");

endmodule : pcs_pll_clock_synth_config
`default_nettype wire

// File: sim/pcs_ref_src.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Free-running reference source and analog VCO level model.
module pcs_ref_src #(
   parameter int REF_HALF_NS = 640  // Reference half period, slow against the system clock.
) (
   input  wire logic [1:0] i_mult_exp, // Multiplier exponent from the block.
   output logic            o_ref,      // Reference clock level.
   output logic            o_vco       // VCO output level.
);
   // The reference never stops, so the block always sees a live source.
   initial begin
      o_ref = 1'b0;
      forever #(REF_HALF_NS) o_ref = ~o_ref;
   end
   // The VCO runs at the reference rate times two to the exponent, unknown taken as zero.
   initial begin
      o_vco = 1'b0;
      forever #(REF_HALF_NS >> ($isunknown(i_mult_exp) ? 2'h0 : i_mult_exp)) o_vco = ~o_vco;
   end
endmodule : pcs_ref_src
`default_nettype wire

// File: sim/pcs_pll_clock_synth_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Register and clock output checks of the clock synthesizer block.
module pcs_pll_clock_synth_config_bench;
   logic i_sys_clk = 1'b0, i_rst = 1'b1, i_gain_step = 1'b0, i_full_duplex = 1'b0;
   logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, rdata;
   logic ref_lvl, vco_lvl, adc_clk, from_vco, rx_clk, vaux, raux, low_pwr, seen, dac_clk;
   logic [1:0] m_exp;
   logic [2:0] bias;
   logic [15:0] n_ref, n_vco, n_adc, n_rx, n_dac;
   int num_errors = 0, compares = 0;
   logic [7:0] addrs [5] = '{8'h04, 8'h06, 8'h07, 8'h13, 8'h05};
   logic [7:0] masked [5] = '{8'h0F, 8'hFF, 8'h11, 8'h07, 8'h00};
   // The system clock, 40 ns period.
   always #20 i_sys_clk = ~i_sys_clk;
   pcs_ref_src src (.i_mult_exp(m_exp), .o_ref(ref_lvl), .o_vco(vco_lvl));
   pcs_pll_clock_synth_config uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(1'b1),
      .i_reference_clock_in(ref_lvl), .i_vco_level(vco_lvl), .i_full_duplex(i_full_duplex),
      .i_gain_step(i_gain_step), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata), .o_pll_mult_exp(m_exp),
      .o_adc_clk(adc_clk), .o_adc_clk_from_vco(from_vco), .o_dac_update_clk(dac_clk),
      .o_receive_clock_out(rx_clk), .o_vco_aux_clock_out(vaux), .o_ref_aux_clock_out(raux),
      .o_adc_low_power(low_pwr), .o_adc_bias(bias), .o_gain_step_seen(seen));
   // Exact comparison of a value seen at the ports.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // Comparison of an edge count, allowing one edge of phase slack.
   task automatic near(input string what, input int exp, input int got);
      compares++;
      if (got < exp - 1 || got > exp + 1) begin
         num_errors++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : near
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_sys_clk);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_sys_clk);
      i_reg_rd = 1'b0;
      chk("read data", {8'h00, exp}, {8'h00, rdata});
   endtask : rd
   // Counts level changes of the generated clocks over a span of cycles.
   task automatic measure(input int cyc);
      logic [4:0] was, now;
      {n_ref, n_vco, n_adc, n_rx, n_dac} = '0;
      was = {raux, vaux, adc_clk, rx_clk, dac_clk};
      repeat (cyc) begin
         @(negedge i_sys_clk);
         now = {raux, vaux, adc_clk, rx_clk, dac_clk};
         n_ref += 16'(now[4] !== was[4]);
         n_vco += 16'(now[3] !== was[3]);
         n_adc += 16'(now[2] !== was[2]);
         n_rx += 16'(now[1] !== was[1]);
         n_dac += 16'(now[0] !== was[0]);
         was = now;
      end
   endtask : measure
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // Cuts a hang short well beyond the expected run length.
   initial begin
      #(40 * 20000);
      num_errors++;
      tally_and_finish();
   end
   // Main test sequence.
   initial begin
      int cnt;
      logic a;
      repeat (12) @(negedge i_sys_clk);
      i_rst = 1'b0;
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      $display("test reset values done");
      foreach (addrs[i]) wr(addrs[i], 8'hFF);
      wr(8'h04, 8'h0F);
      chk("mult exp", 16'h0003, {14'h0, m_exp});
      chk("low power", 16'h0001, {15'h0, low_pwr});
      chk("bias", 16'h0007, {13'h0, bias});
      for (cnt = 0; cnt < 200 && from_vco !== 1'b0; cnt++) @(negedge i_sys_clk);
      foreach (addrs[i]) rd(addrs[i], masked[i]);
      wr(8'h04, 8'h00);
      $display("test masks done");
      for (int k = 0; k < 4; k++) begin
         wr(8'h06, 8'((k << 6) | (k << 2)));
         repeat (300) @(negedge i_sys_clk);
         measure(640);
         near("ref aux edges", 40 >> ((k > 2) ? 2 : k), n_ref);
         near("vco aux edges", 40 >> k, n_vco);
         near("adc edges", 40, n_adc);
      end
      wr(8'h06, 8'h11);
      repeat (300) @(negedge i_sys_clk);
      measure(200);
      chk("disabled edges", 16'h0000, n_ref | n_vco);
      chk("disabled level", 16'h0000, {14'h0, raux, vaux});
      $display("test aux outputs done");
      wr(8'h04, 8'h14);
      for (cnt = 0; cnt < 200 && from_vco !== 1'b1; cnt++) @(negedge i_sys_clk);
      rd(8'h04, 8'h94);
      repeat (64) @(negedge i_sys_clk);
      measure(640);
      near("vco adc edges", 20, n_adc);
      near("rx edges half duplex", 20, n_rx);
      near("dac edges", 40, n_dac);
      $display("test adc source done");
      for (int fd = 0; fd < 2; fd++) begin
         i_full_duplex = fd[0];
         @(adc_clk);
         repeat (5) @(negedge i_sys_clk);
         i_gain_step = 1'b1;
         a = adc_clk;
         n_adc = 0;
         @(negedge i_sys_clk);
         i_gain_step = 1'b0;
         for (cnt = 0; cnt < 2000 && seen !== 1'b1; cnt++) begin
            if (adc_clk !== a)
               n_adc++;
            a = adc_clk;
            @(negedge i_sys_clk);
         end
         chk("step latency edges", 16'(20 + fd), n_adc);
         chk("step seen", 16'h0001, {15'h0, seen});
      end
      measure(640);
      near("rx edges full duplex", 40, n_rx);
      $display("test gain step done");
      i_rst = 1'b1;
      measure(64);
      near("aux edges in reset", 4, n_ref);
      near("vco aux edges in reset", 4, n_vco);
      i_rst = 1'b0;
      rd(8'h04, 8'h00);
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule : pcs_pll_clock_synth_config_bench
`default_nettype wire
